// [usb_cmd_pkg.sv]
/*
 * Constants for the endpoint setup command decoder: command codes,
 * configuration field positions, reset values and timing counts.
 * Assumes a 50 MHz system clock.
 */
`default_nettype none
package usb_cmd_pkg;
	localparam int          EP_COUNT        = 16;
	localparam int          EP_LAST         = 15;
	// Command codes (upper nibble selects group, lower nibble endpoint)
	localparam logic [3:0]  GRP_CFG_WR      = 4'h2;
	localparam logic [3:0]  GRP_CFG_RD      = 4'h3;
	localparam logic [3:0]  GRP_ERR_RD      = 4'hA;
	localparam logic [3:0]  GRP_IMG_RD      = 4'hD;
	localparam logic [7:0]  CMD_IMG_OUT0    = 8'hD0;
	localparam logic [7:0]  CMD_SETUP_ACK   = 8'hF4;
	localparam logic [7:0]  CMD_UNLOCK      = 8'hB0;
	localparam logic [7:0]  CMD_ADDR_WR     = 8'hB6;
	localparam logic [7:0]  CMD_ADDR_RD     = 8'hB7;
	// Endpoint setup fields
	localparam int          BIT_BUFFER_ON   = 7;
	localparam int          BIT_DIRECTION   = 6;
	localparam int          BIT_TWO_BUFFER  = 5;
	localparam int          BIT_ISOCHRONOUS = 4;
	localparam int          SIZE_MSB        = 3;
	localparam logic [7:0]  SETUP_RESET     = 8'h00;
	// Address register fields
	localparam int          BIT_DEVICE_ON   = 7;
	localparam logic [7:0]  ADDR_RESET      = 8'h00;
	localparam logic [6:0]  BUS_RESET_ADDR  = 7'h00;
	// Byte counts of each transaction
	localparam logic [1:0]  LEN_ONE         = 2'd1;
	localparam logic [1:0]  LEN_TWO         = 2'd2;
	// Allocation takes some cycles per endpoint
	localparam int          ALLOC_NS_PER_EP = 40;
	localparam int          CLK_NS          = 20;
	localparam int          ALLOC_CYCLES    =
		(ALLOC_NS_PER_EP + CLK_NS - 1) / CLK_NS;
	localparam logic [11:0] SIZE_UNIT       = 12'h008;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_READ
	} cmd_state_t;
endpackage
`default_nettype wire

// [ep_size_decode.sv]
/*
 * Maps the four-bit size code and isochronous bit of one endpoint
 * to the number of bytes allocated to it, zero when disabled.
 * Assumes the caller passes the stored setup byte.
 */
`default_nettype none
module ep_size_decode
	import usb_cmd_pkg::*;
(
	input  wire logic [7:0]  setup,
	output logic      [11:0] bytes
);
	logic [11:0] base;

	always_comb begin
		// Bulk sizes double per code up to code 3 and hold above it; isochronous use a larger table
		if (setup[BIT_ISOCHRONOUS]) begin
			base = SIZE_UNIT << setup[SIZE_MSB:0];
		end else begin
			base = (setup[SIZE_MSB:0] > 4'h3) ? (SIZE_UNIT << 3)
				: (SIZE_UNIT << setup[1:0]);
		end
		if (!setup[BIT_BUFFER_ON]) begin
			bytes = 12'h000;
		end else if (setup[BIT_TWO_BUFFER]) begin
			bytes = base << 1;
		end else begin
			bytes = base;
		end
	end
endmodule
`default_nettype wire

// [usb_endpoint_setup_commands.sv]
/*
 * Command decoder for the host processor port: endpoint setup,
 * status image, error code, setup acknowledge, unlock and device
 * address commands, plus FIFO allocation and bus reset effects.
 * Assumes cmd_valid/data strobes are synchronous one-cycle pulses
 * from port logic on sys_clk; usb_bus_reset and zlp_acked arrive
 * from the serial engine and are synchronised here.
 */
`default_nettype none
// Functional notes
// - D1 to DF read endpoint status copies
// - Status image read clears nothing
// - F4 acknowledges setup on both control endpoints
// - A0 to AF read endpoint error codes
// - B0 plus two bytes unlocks writes
// - Wide bus uses (N+1)/2 word cycles
// - Bus reset clears every endpoint enable
// - Allocate after ordered setup through endpoint 15
// - Size or enable change invalidates all FIFOs
// - 2x writes, 3x reads endpoint setup
// - Bit 6 selects direction and DMA direction
// - Bit 7 enables buffer and allocation
// - Bit 5 double buffer, bit 4 isochronous
// - B6 writes, B7 reads device address
// - Bus reset uses address zero, keeps register; skipped when a B6 write lands in the same cycle
// - New address active after ZLP acknowledged
module usb_endpoint_setup_commands
	import usb_cmd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        bus_wide,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        wr_strobe,
	input  wire logic [15:0] wr_data,
	input  wire logic        rd_strobe,
	output logic      [15:0] rd_data,
	output logic             rd_last,
	input  wire logic [7:0]  ep_status_in [EP_COUNT],
	input  wire logic [7:0]  ep_error_in  [EP_COUNT],
	input  wire logic        usb_bus_reset,
	input  wire logic        zlp_acked,
	output logic             setup_ack,
	output logic             writes_unlocked,
	output logic [15:0]      ep_buffer_on,
	output logic [15:0]      ep_direction,
	output logic [15:0]      two_buffer_sel,
	output logic [15:0]      isochronous_sel,
	output logic             fifo_invalidate,
	output logic             alloc_busy,
	output logic             alloc_done,
	output logic             device_on,
	output logic [6:0]       usb_addr_field
);
	cmd_state_t  state;
	logic [7:0]  code;
	logic [1:0]  bytes_left;
	logic [7:0]  endpoint_setup [EP_COUNT];
	logic [7:0]  device_address_reg;
	logic [11:0] ep_bytes [EP_COUNT];
	logic [4:0]  next_expected;
	logic [4:0]  alloc_ep;
	logic [1:0]  alloc_wait;
	logic [12:0] alloc_ptr;
	logic        addr_pending;
	logic [1:0]  bus_reset_sync;
	logic [1:0]  zlp_sync;
	logic        bus_reset_prev;
	logic        zlp_prev;
	logic        bus_reset_rise;
	logic        zlp_rise;
	logic [3:0]  ep;
	logic [1:0]  cmd_len;
	logic        cmd_reads;
	logic        cmd_writes;
	logic        take_byte;
	logic [7:0]  wbyte;
	logic [7:0]  read_byte;

	genvar g;
	generate
		for (g = 0; g < EP_COUNT; g++) begin : g_size
			ep_size_decode u_size (
				.setup (endpoint_setup[g]),
				.bytes (ep_bytes[g])
			);
		end
	endgenerate

	// Engine events pass two flip-flops first
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bus_reset_sync <= 2'b00;
			zlp_sync       <= 2'b00;
			bus_reset_prev <= 1'b0;
			zlp_prev       <= 1'b0;
		end else begin
			bus_reset_sync <= {bus_reset_sync[0], usb_bus_reset};
			zlp_sync       <= {zlp_sync[0], zlp_acked};
			bus_reset_prev <= bus_reset_sync[1];
			zlp_prev       <= zlp_sync[1];
		end
	end
	assign bus_reset_rise = bus_reset_sync[1] & ~bus_reset_prev;
	assign zlp_rise       = zlp_sync[1] & ~zlp_prev;

	assign ep = code[3:0];

	// Transaction length and direction per command code
	always_comb begin
		cmd_len    = 2'd0;
		cmd_reads  = 1'b0;
		cmd_writes = 1'b0;
		case (cmd_code[7:4])
			GRP_CFG_WR: begin
				cmd_len    = LEN_ONE;
				cmd_writes = 1'b1;
			end
			GRP_CFG_RD, GRP_ERR_RD: begin
				cmd_len   = LEN_ONE;
				cmd_reads = 1'b1;
			end
			GRP_IMG_RD: begin
				// D0 belongs to the neighbouring decoder
				if (cmd_code != CMD_IMG_OUT0) begin
					cmd_len   = LEN_ONE;
					cmd_reads = 1'b1;
				end
			end
			default: begin
				if (cmd_code == CMD_UNLOCK) begin
					cmd_len    = LEN_TWO;
					cmd_writes = 1'b1;
				end else if (cmd_code == CMD_ADDR_WR) begin
					cmd_len    = LEN_ONE;
					cmd_writes = 1'b1;
				end else if (cmd_code == CMD_ADDR_RD) begin
					cmd_len   = LEN_ONE;
					cmd_reads = 1'b1;
				end
			end
		endcase
	end

	// Read multiplexer; status copy is sampled without side effects
	always_comb begin
		case (code[7:4])
			GRP_CFG_RD: read_byte = endpoint_setup[ep];
			GRP_ERR_RD: read_byte = ep_error_in[ep];
			GRP_IMG_RD: read_byte = ep_status_in[ep];
			default:    read_byte = device_address_reg;
		endcase
	end

	assign take_byte = (state == ST_WRITE) && wr_strobe;
	assign wbyte     = wr_data[7:0];

	// Command sequencing; one wide cycle carries two bytes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state      <= ST_IDLE;
			code       <= 8'h00;
			bytes_left <= 2'd0;
		end else if (cmd_valid) begin
			code       <= cmd_code;
			bytes_left <= cmd_len;
			if (cmd_writes) begin
				state <= ST_WRITE;
			end else if (cmd_reads) begin
				state <= ST_READ;
			end else begin
				state <= ST_IDLE;
			end
		end else if ((take_byte || (state == ST_READ && rd_strobe))) begin
			if (bus_wide || bytes_left == LEN_ONE) begin
				state      <= ST_IDLE;
				bytes_left <= 2'd0;
			end else begin
				bytes_left <= bytes_left - 2'd1;
			end
		end
	end

	// Read data; upper byte of wide reads is zero filler
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
			rd_last <= 1'b0;
		end else begin
			rd_last <= 1'b0;
			if (state == ST_READ && rd_strobe) begin
				rd_data <= {8'h00, read_byte};
				rd_last <= 1'b1;
			end
		end
	end

	// Setup acknowledge pulse, no data phase
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			setup_ack <= 1'b0;
		end else begin
			setup_ack <= cmd_valid && (cmd_code == CMD_SETUP_ACK);
		end
	end

	// Unlock once both bytes are written
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			writes_unlocked <= 1'b0;
		end else if (take_byte && code == CMD_UNLOCK
			&& (bus_wide || bytes_left == LEN_ONE)) begin
			writes_unlocked <= 1'b1;
		end
	end

	// Endpoint setup storage and ordered allocation tracking
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < EP_COUNT; i++) begin
				endpoint_setup[i] <= SETUP_RESET;
			end
			next_expected   <= 5'd0;
			fifo_invalidate <= 1'b0;
		end else begin
			fifo_invalidate <= 1'b0;
			if (bus_reset_rise) begin
				for (int i = 0; i < EP_COUNT; i++) begin
					endpoint_setup[i][BIT_BUFFER_ON] <= 1'b0;
				end
			end else if (take_byte && code[7:4] == GRP_CFG_WR) begin
				endpoint_setup[ep] <= wbyte;
				if (ep == next_expected[3:0] && !next_expected[4])
					begin
					next_expected <= (ep == 4'(EP_LAST)) ? 5'd0
						: next_expected + 5'd1;
				end else begin
					next_expected <= (ep == 4'h0) ? 5'd1 : 5'd0;
				end
				if (wbyte[BIT_BUFFER_ON] != endpoint_setup[ep][BIT_BUFFER_ON]
					|| wbyte[SIZE_MSB:0] != endpoint_setup[ep][SIZE_MSB:0])
					begin
					fifo_invalidate <= 1'b1;
				end
			end
		end
	end

	// Allocation walks all endpoints after the last is written
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			alloc_busy <= 1'b0;
			alloc_done <= 1'b0;
			alloc_ep   <= 5'd0;
			alloc_wait <= 2'd0;
			alloc_ptr  <= 13'h0000;
		end else if (take_byte && code[7:4] == GRP_CFG_WR) begin
			alloc_done <= 1'b0;
			if (ep == 4'(EP_LAST) && next_expected == 5'(EP_LAST)) begin
				alloc_busy <= 1'b1;
				alloc_ep   <= 5'd0;
				alloc_wait <= 2'(ALLOC_CYCLES - 1);
				alloc_ptr  <= 13'h0000;
			end
		end else if (alloc_busy) begin
			if (alloc_wait != 2'd0) begin
				alloc_wait <= alloc_wait - 2'd1;
			end else begin
				alloc_ptr  <= alloc_ptr + {1'b0, ep_bytes[alloc_ep[3:0]]};
				alloc_wait <= 2'(ALLOC_CYCLES - 1);
				if (alloc_ep == 5'(EP_LAST)) begin
					alloc_busy <= 1'b0;
					alloc_done <= 1'b1;
				end else begin
					alloc_ep <= alloc_ep + 5'd1;
				end
			end
		end
	end

	// Per-endpoint decoded fields
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ep_buffer_on    <= 16'h0000;
			ep_direction    <= 16'h0000;
			two_buffer_sel  <= 16'h0000;
			isochronous_sel <= 16'h0000;
		end else begin
			for (int i = 0; i < EP_COUNT; i++) begin
				ep_buffer_on[i]    <= endpoint_setup[i][BIT_BUFFER_ON]
					&& alloc_done;
				ep_direction[i]    <= endpoint_setup[i][BIT_DIRECTION];
				two_buffer_sel[i]  <= endpoint_setup[i][BIT_TWO_BUFFER];
				isochronous_sel[i] <= endpoint_setup[i][BIT_ISOCHRONOUS];
			end
		end
	end

	// Address register and the address actually in use
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			device_address_reg <= ADDR_RESET;
			addr_pending       <= 1'b0;
			device_on          <= 1'b0;
			usb_addr_field     <= BUS_RESET_ADDR;
		end else begin
			if (take_byte && code == CMD_ADDR_WR) begin
				device_address_reg <= wbyte;
				device_on          <= wbyte[BIT_DEVICE_ON];
				addr_pending       <= 1'b1;
			end else if (bus_reset_rise) begin
				usb_addr_field <= BUS_RESET_ADDR;
				device_on      <= 1'b1;
				addr_pending   <= 1'b0;
			end else if (zlp_rise && addr_pending) begin
				usb_addr_field <= device_address_reg[6:0];
				addr_pending   <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [ep_cmd_assertions.sv]
/* Port assertions for the endpoint setup decoder.
   Assumes the decoder ports and package; bound below. */
`default_nettype none
module ep_cmd_checker
	import usb_cmd_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        wr_strobe,
	input wire logic        rd_strobe,
	input wire logic [15:0] rd_data,
	input wire logic        rd_last,
	input wire logic [7:0]  ep_status_in [EP_COUNT],
	input wire logic        usb_bus_reset,
	input wire logic        zlp_acked,
	input wire logic        setup_ack,
	input wire logic [15:0] ep_buffer_on,
	input wire logic        alloc_busy,
	input wire logic        alloc_done,
	input wire logic        device_on,
	input wire logic [6:0]  usb_addr_field
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] code;
	logic       armed;
	logic [3:0] ev_age;
	logic [7:0] img_now;
	assign img_now = ep_status_in[code[3:0]];
	always_ff @(posedge sys_clk) begin
		if (cmd_valid)
			code <= cmd_code;
	end
	// Command still waiting for its first data cycle
	always_ff @(posedge sys_clk) begin
		armed <= resetn && (cmd_valid || (armed && !rd_strobe && !wr_strobe));
	end
	// Cycles since the last engine event
	always_ff @(posedge sys_clk) begin
		if (!resetn || usb_bus_reset || zlp_acked)
			ev_age <= 4'h0;
		else if (ev_age != 4'hF)
			ev_age <= ev_age + 4'h1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	setup_ack_pulse_a: assert property (
		cmd_valid && cmd_code == CMD_SETUP_ACK |=> setup_ack ##1 !setup_ack)
		else $error("setup ack pulse missing");
	ack_cause_a: assert property (
		setup_ack |-> $past(cmd_valid) && $past(cmd_code) == CMD_SETUP_ACK)
		else $error("setup ack without its command");
	read_answer_a: assert property (
		rd_last |-> $past(rd_strobe) && rd_data[15:8] == 8'h00)
		else $error("read answer out of place");
	image_read_a: assert property (
		armed && rd_strobe && !cmd_valid && code[7:4] == GRP_IMG_RD &&
		code != CMD_IMG_OUT0 |=> rd_last && rd_data[7:0] == $past(img_now))
		else $error("status image read wrong");
	bus_reset_a: assert property (
		$rose(usb_bus_reset) |-> ##[2:5] ep_buffer_on == 16'h0000 &&
		device_on && usb_addr_field == 7'h00)
		else $error("bus reset effects missing");
	alloc_time_a: assert property (
		$rose(alloc_busy) |-> !alloc_done[*8] ##[22:26] alloc_done)
		else $error("allocation walk length wrong");
	buffer_needs_alloc_a: assert property (
		ep_buffer_on != 16'h0000 |-> $past(alloc_done))
		else $error("buffer on before allocation");
	address_defer_a: assert property (
		$changed(usb_addr_field) |-> ev_age < 4'h6)
		else $error("address changed without event");
	cover property (setup_ack);
	cover property ($rose(alloc_done));
	cover property ($changed(usb_addr_field) && ev_age > 4'h0);
endmodule
bind usb_endpoint_setup_commands ep_cmd_checker chk (.sys_clk, .resetn,
	.cmd_valid, .cmd_code, .wr_strobe, .rd_strobe, .rd_data, .rd_last,
	.ep_status_in, .usb_bus_reset, .zlp_acked, .setup_ack, .ep_buffer_on,
	.alloc_busy, .alloc_done, .device_on, .usb_addr_field);
`default_nettype wire

// [host_model.sv]
/* Host processor model issuing commands and data cycles.
   Assumes it is driven on falling clock edges. */
`default_nettype none
module host_model (
	input  wire logic        sys_clk,
	output logic             cmd_valid,
	output logic [7:0]       cmd_code,
	output logic             wr_strobe,
	output logic [15:0]      wr_data,
	output logic             rd_strobe,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_last
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_code  = 8'h5A;
		wr_strobe = 1'b0;
		wr_data   = 16'hA5A5;
		rd_strobe = 1'b0;
	end
	// Only decoder codes issued, never a validate or clear
	task automatic cmd(input logic [7:0] code);
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_code  = code;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		cmd_code  = ~code;
	endtask
	task automatic wr(input logic [15:0] data);
		wr_strobe = 1'b1;
		wr_data   = data;
		@(negedge sys_clk);
		wr_strobe = 1'b0;
		wr_data   = ~data;
	endtask
	task automatic rd(output logic [15:0] data);
		data      = 16'hXXXX;
		rd_strobe = 1'b1;
		@(negedge sys_clk);
		rd_strobe = 1'b0;
		// Answer stands one cycle; sample before waiting
		for (int n = 0; n < 4; n++) begin
			if (rd_last) begin
				data = {8'h00, rd_data[7:0]};
				break;
			end
			@(negedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// [usb_endpoint_setup_commands_tb.sv]
/* Self-checking bench for the endpoint setup decoder.
   Assumes the host model and bound checker are compiled. */
`default_nettype none
module usb_endpoint_setup_commands_tb;
	import usb_cmd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk;
	logic        resetn;
	logic        bus_wide;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic        wr_strobe;
	logic [15:0] wr_data;
	logic        rd_strobe;
	logic [15:0] rd_data;
	logic        rd_last;
	logic [7:0]  ep_status_in [EP_COUNT];
	logic [7:0]  ep_error_in  [EP_COUNT];
	logic        usb_bus_reset;
	logic        zlp_acked;
	logic        setup_ack;
	logic        writes_unlocked;
	logic [15:0] ep_buffer_on;
	logic [15:0] ep_direction;
	logic [15:0] two_buffer_sel;
	logic [15:0] isochronous_sel;
	logic        fifo_invalidate;
	logic        alloc_busy;
	logic        alloc_done;
	logic        device_on;
	logic [6:0]  usb_addr_field;
	logic [15:0] got;
	int          fail_count;
	int          comparisons;
	int          model_setup [EP_COUNT];
	int          model_addr;
	usb_endpoint_setup_commands DUT (.sys_clk, .resetn, .bus_wide,
		.cmd_valid, .cmd_code, .wr_strobe, .wr_data, .rd_strobe, .rd_data,
		.rd_last, .ep_status_in, .ep_error_in, .usb_bus_reset, .zlp_acked,
		.setup_ack, .writes_unlocked, .ep_buffer_on, .ep_direction,
		.two_buffer_sel, .isochronous_sel, .fifo_invalidate, .alloc_busy,
		.alloc_done, .device_on, .usb_addr_field);
	host_model host (.sys_clk, .cmd_valid, .cmd_code, .wr_strobe, .wr_data,
		.rd_strobe, .rd_data, .rd_last);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [15:0] act, input logic [15:0] exp);
		comparisons++;
		if (act !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
		end
	endtask
	task automatic finish_test;
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic expect_rd(input logic [7:0] code, input int exp);
		host.cmd(code);
		host.rd(got);
		check(got, 16'(exp & 'hFF));
	endtask
	task automatic wr8(input logic [7:0] code, input int data);
		host.cmd(code);
		host.wr(16'(data));
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic check_cfg;
		logic [15:0] e [4];
		for (int i = 0; i < EP_COUNT; i++)
			for (int b = 0; b < 4; b++)
				e[b][i] = model_setup[i][7 - b];
		check(ep_buffer_on, e[0]);
		check(ep_direction, e[1]);
		check(two_buffer_sel, e[2]);
		check(isochronous_sel, e[3]);
	endtask
	task automatic read_setups;
		for (int i = 0; i < EP_COUNT; i++)
			expect_rd(8'h30 + 8'(i), model_setup[i]);
	endtask
	// Span of about forty times the expected run
	initial begin
		#(20 * 20000);
		fail_count++;
		finish_test;
	end
	initial begin
		resetn = 1'b0;
		bus_wide = 1'b0;
		usb_bus_reset = 1'b0;
		zlp_acked = 1'b0;
		fail_count = 0;
		comparisons = 0;
		void'($urandom(32'hC888));
		foreach (ep_status_in[i]) begin
			ep_status_in[i] = 8'($urandom);
			ep_error_in[i] = 8'($urandom);
			model_setup[i] = 0;
		end
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		read_setups;
		expect_rd(CMD_ADDR_RD, 0);
		host.cmd(CMD_UNLOCK);
		host.wr(16'h00AA);
		check(writes_unlocked, 0);
		@(negedge sys_clk);
		host.wr(16'h0055);
		repeat (2) @(negedge sys_clk);
		check(writes_unlocked, 1);
		// Sizes kept within the bulk range
		for (int i = 0; i < EP_COUNT; i++) begin
			model_setup[i] = $urandom & 'hF3;
			wr8(8'h20 + 8'(i), model_setup[i]);
		end
		check(alloc_busy, 1);
		for (int n = 0; n < 100 && !alloc_done; n++)
			@(negedge sys_clk);
		check(alloc_done, 1);
		check(alloc_busy, 0);
		@(negedge sys_clk);
		check_cfg;
		read_setups;
		for (int i = 1; i < EP_COUNT; i++) begin
			expect_rd(8'hD0 + 8'(i), ep_status_in[i]);
			expect_rd(8'hD0 + 8'(i), ep_status_in[i]);
		end
		for (int i = 0; i < EP_COUNT; i++)
			expect_rd(8'hA0 + 8'(i), ep_error_in[i]);
		host.cmd(CMD_SETUP_ACK);
		check(setup_ack, 1);
		@(negedge sys_clk);
		check(setup_ack, 0);
		model_addr = ($urandom & 'hFF) | 1;
		wr8(CMD_ADDR_WR, model_addr);
		expect_rd(CMD_ADDR_RD, model_addr);
		check(device_on, 16'(model_addr >> 7));
		check(usb_addr_field, 0);
		zlp_acked = 1'b1;
		repeat (2) @(negedge sys_clk);
		zlp_acked = 1'b0;
		repeat (4) @(negedge sys_clk);
		check(usb_addr_field, 16'(model_addr & 'h7F));
		usb_bus_reset = 1'b1;
		repeat (3) @(negedge sys_clk);
		usb_bus_reset = 1'b0;
		repeat (3) @(negedge sys_clk);
		foreach (model_setup[i])
			model_setup[i] &= 'h7F;
		check_cfg;
		check(device_on, 1);
		check(usb_addr_field, 0);
		expect_rd(CMD_ADDR_RD, model_addr);
		read_setups;
		model_setup[1] ^= 'h80;
		host.cmd(8'h21);
		host.wr(16'(model_setup[1]));
		check(fifo_invalidate, 1);
		@(negedge sys_clk);
		check(fifo_invalidate, 0);
		resetn = 1'b0;
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		bus_wide = 1'b1;
		check(writes_unlocked, 0);
		host.cmd(CMD_UNLOCK);
		host.wr(16'hAA55);
		repeat (2) @(negedge sys_clk);
		check(writes_unlocked, 1);
		expect_rd(8'h31, 0);
		finish_test;
	end
endmodule
`default_nettype wire
